// file: temp_seq_defs.svh
/*
  Constants of the conversion sequencer: times, pointers, fields, resets.
  Assumes inclusion by bare name.
*/
// ****************************************************************
// Behaviour
// - Wait 1.5 ms power-up before first conversion
// - Result reads 0x8000 until first conversion
// - Result written after each conversion or average
// - Result is 16-bit two's complement, 7.8125 mC
// - Limit registers share the result format
// - Free-running cycle: active then standby
// - Period and sample-count fields set timing
// - Averaging accumulates, reports only the mean
// - One conversion 15.5 ms, scaled by count
// - Defaults: eight samples, one second cycle
// - Stuck bus clock releases data line
// - Stored setting can start in power-down
// - Two-bit operating selector picks behaviour
// - Selector 00 converts continuously
// - Selector 01 aborts into power-down
// - Selector 11 in power-down: one shot
// - Fresh flag set on result, cleared on result or config read
// ****************************************************************
`ifndef TEMP_SEQ_DEFS_SVH
`define TEMP_SEQ_DEFS_SVH

// System clock rate
`define CLK_MHZ 250
// Times in microseconds
`define PWRUP_US 1500
`define CYCLE_PERIOD_SELECT_US 15500
`define BUS_TMO_US 25000
`define MS_US 1000

// Register pointers
`define A_TEMP 2'h0
`define A_CFG 2'h1
`define A_HI 2'h2
`define A_LO 2'h3

// Configuration fields
`define CFG_DR 13
`define CFG_MOD 11:10
`define CFG_CYCLE_PERIOD_SELECT 9:7
`define CFG_AVG 6:5

// Reset values
`define RST_TEMP 16'h8000
`define RST_HI 16'h6000
`define RST_LO 16'h8000
`define RST_CYCLE_PERIOD_SELECT 3'h4
`define RST_AVG 2'h1

`endif

// file: temp_seq_pkg.sv
/*
  Types of the conversion sequencer.
  Assumes temp_seq_defs.svh is on the include path.
*/
`include "temp_seq_defs.svh"

package temp_seq_pkg;

  // Operating selector codes
  typedef enum logic [1:0] {
    SEL_FREE = 2'h0,
    SEL_PDOWN = 2'h1,
    SEL_FREE_ALT = 2'h2,
    SEL_SHOT = 2'h3
  } op_sel_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_PWRUP = 4'h1,
    ST_ACTIVE = 4'h2,
    ST_STANDBY = 4'h4,
    ST_IDLE = 4'h8
  } seq_state_t;

  // Register request carried across the clock boundary
  typedef struct packed {
    logic write;
    logic [1:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

endpackage

// file: temp_conversion_sequencer.sv
/*
  Conversion sequencer and result store of a digital temperature sensor,
  register side on the bus clock.
  Assumes a protocol engine on bus_clk issues requests, a
  front end on clk_sys supplies samples, and nrst is a
  power-on reset shared by both domains.
*/
`timescale 1ns/1ps
`include "temp_seq_defs.svh"

module temp_conversion_sequencer #(
  parameter int unsigned PWRUP_CYC = `PWRUP_US * `CLK_MHZ, // Power-up wait
  parameter int unsigned CYCLE_PERIOD_SELECT_CYC = `CYCLE_PERIOD_SELECT_US * `CLK_MHZ, // One conversion
  parameter int unsigned MS_CYC = `MS_US * `CLK_MHZ, // One millisecond
  parameter int unsigned TMO_CYC = `BUS_TMO_US * `CLK_MHZ // Bus timeout
) (
  input wire logic clk_sys, // System clock, 250 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic bus_clk, // Link clock of the protocol engine
  input wire logic req_valid, // Register request offered
  output logic req_ready, // Request can be taken
  input wire logic req_write, // 1 write, 0 read
  input wire logic [1:0] req_addr, // Register pointer
  input wire logic [15:0] req_wdata, // Write data
  output logic rsp_valid, // Request done, one bus_clk pulse
  output logic [15:0] rsp_rdata, // Read data
  input wire logic xfer_active, // Engine is inside a transfer
  input wire logic sda_pull, // Engine wants data line low
  input wire logic scl_in, // Bus clock pin
  output logic sda_out, // Data line drive value
  output logic sda_oe_n, // Data line enable, low drives
  input wire logic pd_strap, // Stored start-in-power-down setting
  input wire logic [15:0] adc_data, // Front-end sample
  output logic adc_en // Front end powered, active period
);

  // ****************************************************************
  // Link domain: request holder and answer capture
  // ****************************************************************
  temp_seq_pkg::reg_req_t lreq_q, lreq_d; // Held request, stable until ack
  logic pend_q, pend_d; // Request outstanding
  logic req_tgl_q, req_tgl_d; // Request event toggle
  logic rsp_valid_q, rsp_valid_d; // Answer pulse
  logic [15:0] rsp_rdata_q, rsp_rdata_d; // Answer data
  logic sda_oe_n_q, sda_oe_n_d; // Data line enable
  logic ack_s1_q, ack_s2_q, ack_s3_q; // Ack toggle sync
  logic tmo_s1_q, tmo_s2_q; // Timeout level sync
  logic ack_tgl_q; // Ack toggle, system domain
  logic tmo_q; // Timeout level, system domain
  logic [15:0] rdata_q; // Read data, system domain

  assign req_ready = ~pend_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign sda_out = 1'h0;
  assign sda_oe_n = sda_oe_n_q;

  // Next values of the link side
  always_comb begin
    lreq_d = lreq_q;
    pend_d = pend_q;
    req_tgl_d = req_tgl_q;
    rsp_valid_d = 1'h0;
    rsp_rdata_d = rsp_rdata_q;
    sda_oe_n_d = ~(sda_pull & ~tmo_s2_q);
    if (req_valid && !pend_q) begin
      // Hold the request until acknowledged
      lreq_d = '{write: req_write, addr: req_addr, wdata: req_wdata};
      pend_d = 1'h1;
      req_tgl_d = ~req_tgl_q;
    end else if (ack_s2_q != ack_s3_q) begin
      pend_d = 1'h0;
      rsp_valid_d = 1'h1;
      rsp_rdata_d = rdata_q;
    end
  end

  // Link registers
  always_ff @(posedge bus_clk or negedge nrst) begin
    if (!nrst) begin
      lreq_q <= '0;
      pend_q <= 1'h0;
      req_tgl_q <= 1'h0;
      rsp_valid_q <= 1'h0;
      rsp_rdata_q <= 16'h0000;
      sda_oe_n_q <= 1'h1;
      ack_s1_q <= 1'h0;
      ack_s2_q <= 1'h0;
      ack_s3_q <= 1'h0;
      tmo_s1_q <= 1'h0;
      tmo_s2_q <= 1'h0;
    end else begin
      lreq_q <= lreq_d;
      pend_q <= pend_d;
      req_tgl_q <= req_tgl_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_rdata_q <= rsp_rdata_d;
      sda_oe_n_q <= sda_oe_n_d;
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      tmo_s1_q <= tmo_q;
      tmo_s2_q <= tmo_s1_q;
    end
  end

  // ****************************************************************
  // System domain: synchronisers
  // ****************************************************************
  logic rq_s1_q, rq_s2_q, rq_s3_q; // Request toggle sync
  logic scl_s1_q, scl_s2_q, scl_s3_q; // Bus clock pin sync
  logic act_s1_q, act_s2_q; // Transfer level sync
  logic pd_s1_q, pd_s2_q; // Strap sync

  // Two flops before any logic; third stage only for edges
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rq_s1_q <= 1'h0;
      rq_s2_q <= 1'h0;
      rq_s3_q <= 1'h0;
      scl_s1_q <= 1'h1;
      scl_s2_q <= 1'h1;
      scl_s3_q <= 1'h1;
      act_s1_q <= 1'h0;
      act_s2_q <= 1'h0;
      pd_s1_q <= 1'h0;
      pd_s2_q <= 1'h0;
    end else begin
      rq_s1_q <= req_tgl_q;
      rq_s2_q <= rq_s1_q;
      rq_s3_q <= rq_s2_q;
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      act_s1_q <= xfer_active;
      act_s2_q <= act_s1_q;
      pd_s1_q <= pd_strap;
      pd_s2_q <= pd_s1_q;
    end
  end

  // ****************************************************************
  // System domain: stuck bus clock watchdog
  // ****************************************************************
  logic [31:0] tmo_cnt_q, tmo_cnt_d; // Cycles since last bus clock edge
  logic tmo_d; // Next timeout level

  // Restart on any bus clock edge or outside a transfer
  always_comb begin
    tmo_cnt_d = tmo_cnt_q;
    tmo_d = tmo_q;
    if (!act_s2_q || (scl_s2_q != scl_s3_q)) begin
      tmo_cnt_d = 32'h0000_0000;
      tmo_d = 1'h0;
    end else if (tmo_cnt_q == TMO_CYC - 1) begin
      tmo_d = 1'h1;
    end else begin
      tmo_cnt_d = tmo_cnt_q + 32'h0000_0001;
    end
  end

  // Watchdog registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tmo_cnt_q <= 32'h0000_0000;
      tmo_q <= 1'h0;
    end else begin
      tmo_cnt_q <= tmo_cnt_d;
      tmo_q <= tmo_d;
    end
  end

  // ****************************************************************
  // System domain: sequencer and registers
  // ****************************************************************
  temp_seq_pkg::seq_state_t st_q, st_d; // Sequencer state
  temp_seq_pkg::op_sel_t mode_q, mode_d; // Operating selector
  logic [2:0] cycle_period_select_q, cycle_period_select_d; // Cycle period select
  logic [1:0] avg_q, avg_d; // Sample count select
  logic [1:0] cyc_avg_q, cyc_avg_d; // Count latched for this cycle
  logic [31:0] cnt_q, cnt_d; // Power-up and conversion timer
  logic [31:0] pre_q, pre_d; // Millisecond prescaler
  logic [15:0] ms_q, ms_d; // Milliseconds since cycle start
  logic [6:0] nconv_q, nconv_d; // Conversions done in this cycle
  logic signed [22:0] acc_q, acc_d; // Sum of samples
  logic shot_q, shot_d; // Current cycle is a one shot
  logic dr_q, dr_d; // Result-fresh flag
  logic [15:0] temp_q, temp_d; // Temperature result
  logic [15:0] hi_q, hi_d; // Upper threshold
  logic [15:0] lo_q, lo_d; // Lower threshold
  logic [15:0] rdata_d; // Next read data
  logic ack_tgl_d; // Next ack toggle

  assign adc_en = (st_q == temp_seq_pkg::ST_ACTIVE);

  // Period per select code, in milliseconds
  function automatic logic [15:0] period_ms(input logic [2:0] sel);
    unique case (sel)
      3'h0: period_ms = 16'h0010;
      3'h1: period_ms = 16'h007D;
      3'h2: period_ms = 16'h00FA;
      3'h3: period_ms = 16'h01F4;
      3'h4: period_ms = 16'h03E8;
      3'h5: period_ms = 16'h0FA0;
      3'h6: period_ms = 16'h1F40;
      default: period_ms = 16'h3E80;
    endcase
  endfunction

  // Samples 1, 8, 32, 64 as last index and shift
  function automatic logic [6:0] last_idx(input logic [1:0] sel);
    unique case (sel)
      2'h0: last_idx = 7'h00;
      2'h1: last_idx = 7'h07;
      2'h2: last_idx = 7'h1F;
      default: last_idx = 7'h3F;
    endcase
  endfunction

  function automatic logic [2:0] avg_shift(input logic [1:0] sel);
    unique case (sel)
      2'h0: avg_shift = 3'h0;
      2'h1: avg_shift = 3'h3;
      2'h2: avg_shift = 3'h5;
      default: avg_shift = 3'h6;
    endcase
  endfunction

  // Sequencer next state; bus writes last so an abort wins
  always_comb begin
    logic start;
    logic signed [22:0] sum;
    logic signed [22:0] mean;
    logic [1:0] wsel;
    start = 1'h0;
    sum = acc_q + {{7{adc_data[15]}}, adc_data};
    mean = sum >>> avg_shift(cyc_avg_q);
    wsel = lreq_q.wdata[`CFG_MOD];
    st_d = st_q;
    mode_d = mode_q;
    cycle_period_select_d = cycle_period_select_q;
    avg_d = avg_q;
    cyc_avg_d = cyc_avg_q;
    cnt_d = cnt_q;
    pre_d = pre_q;
    ms_d = ms_q;
    nconv_d = nconv_q;
    acc_d = acc_q;
    shot_d = shot_q;
    dr_d = dr_q;
    temp_d = temp_q;
    hi_d = hi_q;
    lo_d = lo_q;
    rdata_d = rdata_q;
    ack_tgl_d = ack_tgl_q;
    // Read side: the fresh flag is cleared before any set below
    if (rq_s2_q != rq_s3_q && !lreq_q.write) begin
      unique case (lreq_q.addr)
        `A_TEMP: rdata_d = temp_q;
        `A_CFG: rdata_d = {2'h0, dr_q, 1'h0, mode_q, cycle_period_select_q, avg_q, 5'h00};
        `A_HI: rdata_d = hi_q;
        `A_LO: rdata_d = lo_q;
      endcase
      if (lreq_q.addr == `A_TEMP || lreq_q.addr == `A_CFG) begin
        dr_d = 1'h0;
      end
    end
    // Cycle time, counted only while a cycle runs
    if (st_q == temp_seq_pkg::ST_ACTIVE || st_q == temp_seq_pkg::ST_STANDBY) begin
      if (pre_q == MS_CYC - 1) begin
        pre_d = 32'h0000_0000;
        ms_d = ms_q + 16'h0001;
      end else begin
        pre_d = pre_q + 32'h0000_0001;
      end
    end
    unique case (st_q)
      temp_seq_pkg::ST_PWRUP: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (cnt_q == PWRUP_CYC - 1) begin
          if (pd_s2_q) begin
            st_d = temp_seq_pkg::ST_IDLE;
            mode_d = temp_seq_pkg::SEL_PDOWN;
          end else begin
            start = 1'h1;
          end
        end
      end
      temp_seq_pkg::ST_ACTIVE: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (cnt_q == CYCLE_PERIOD_SELECT_CYC - 1) begin
          cnt_d = 32'h0000_0000;
          if (nconv_q == last_idx(cyc_avg_q)) begin
            temp_d = mean[15:0];
            dr_d = 1'h1;
            acc_d = '0;
            nconv_d = 7'h00;
            if (shot_q) begin
              st_d = temp_seq_pkg::ST_IDLE;
              mode_d = temp_seq_pkg::SEL_PDOWN;
              shot_d = 1'h0;
            end else begin
              st_d = temp_seq_pkg::ST_STANDBY;
            end
          end else begin
            acc_d = sum;
            nconv_d = nconv_q + 7'h01;
          end
        end
      end
      temp_seq_pkg::ST_STANDBY: begin
        // Next count ends it, so no extra clock
        if (ms_d >= period_ms(cycle_period_select_q)) begin
          start = 1'h1;
        end
      end
      temp_seq_pkg::ST_IDLE: begin
        st_d = st_q;
      end
      default: begin
        st_d = temp_seq_pkg::ST_IDLE;
      end
    endcase
    // Write side; writes during power-up are ignored
    if (rq_s2_q != rq_s3_q) begin
      ack_tgl_d = ~ack_tgl_q;
      if (lreq_q.write && st_q != temp_seq_pkg::ST_PWRUP) begin
        unique case (lreq_q.addr)
          `A_CFG: begin
            cycle_period_select_d = lreq_q.wdata[`CFG_CYCLE_PERIOD_SELECT];
            avg_d = lreq_q.wdata[`CFG_AVG];
            if (wsel == temp_seq_pkg::SEL_PDOWN) begin
              mode_d = temp_seq_pkg::SEL_PDOWN;
              st_d = temp_seq_pkg::ST_IDLE;
              shot_d = 1'h0;
              start = 1'h0;
            end else if (wsel == temp_seq_pkg::SEL_SHOT) begin
              if (st_q == temp_seq_pkg::ST_IDLE) begin
                mode_d = temp_seq_pkg::SEL_SHOT;
                shot_d = 1'h1;
                start = 1'h1;
                avg_d = lreq_q.wdata[`CFG_AVG];
              end
            end else begin
              mode_d = temp_seq_pkg::op_sel_t'(wsel);
              if (st_q == temp_seq_pkg::ST_IDLE) begin
                start = 1'h1;
              end
            end
          end
          `A_HI: hi_d = lreq_q.wdata;
          `A_LO: lo_d = lreq_q.wdata;
          default: rdata_d = rdata_d;
        endcase
      end
    end
    // New cycle: active first, sample count fixed for it
    if (start) begin
      st_d = temp_seq_pkg::ST_ACTIVE;
      cnt_d = 32'h0000_0000;
      pre_d = 32'h0000_0000;
      ms_d = 16'h0000;
      nconv_d = 7'h00;
      acc_d = '0;
      cyc_avg_d = avg_d;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= temp_seq_pkg::ST_PWRUP;
      mode_q <= temp_seq_pkg::SEL_FREE;
      cycle_period_select_q <= `RST_CYCLE_PERIOD_SELECT;
      avg_q <= `RST_AVG;
      cyc_avg_q <= `RST_AVG;
      cnt_q <= 32'h0000_0000;
      pre_q <= 32'h0000_0000;
      ms_q <= 16'h0000;
      nconv_q <= 7'h00;
      acc_q <= '0;
      shot_q <= 1'h0;
      dr_q <= 1'h0;
      temp_q <= `RST_TEMP;
      hi_q <= `RST_HI;
      lo_q <= `RST_LO;
      rdata_q <= 16'h0000;
      ack_tgl_q <= 1'h0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      cycle_period_select_q <= cycle_period_select_d;
      avg_q <= avg_d;
      cyc_avg_q <= cyc_avg_d;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      ms_q <= ms_d;
      nconv_q <= nconv_d;
      acc_q <= acc_d;
      shot_q <= shot_d;
      dr_q <= dr_d;
      temp_q <= temp_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      rdata_q <= rdata_d;
      ack_tgl_q <= ack_tgl_d;
    end
  end

endmodule // temp_conversion_sequencer

// file: seq_monitor.sv
/*
  Checker of the conversion sequencer, watching only its ports.
  Assumes the bind at the foot of this file.
*/
`timescale 1ns/1ps
module seq_monitor #(
  parameter int unsigned PWRUP_CYC = 20, // Power-up wait
  parameter int unsigned CYCLE_PERIOD_SELECT_CYC = 10, // One conversion
  parameter int unsigned MS_CYC = 4, // One millisecond
  parameter int unsigned TMO_CYC = 50 // Bus timeout
) (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Reset, active low
  input wire logic bus_clk, // Link clock
  input wire logic req_valid, // Request offered
  input wire logic req_ready, // Request can be taken
  input wire logic req_write, // Write flag
  input wire logic [1:0] req_addr, // Register pointer
  input wire logic [15:0] req_wdata, // Write data
  input wire logic rsp_valid, // Answer pulse
  input wire logic [15:0] rsp_rdata, // Read data
  input wire logic xfer_active, // Transfer open
  input wire logic sda_pull, // Engine pulls data low
  input wire logic scl_in, // Bus clock pin
  input wire logic sda_out, // Data drive value
  input wire logic sda_oe_n, // Data enable, low drives
  input wire logic pd_strap, // Start powered down
  input wire logic [15:0] adc_data, // Front-end sample
  input wire logic adc_en // Active period
);
  // ****************************************************************
  // Helper counters
  // ****************************************************************
  logic [31:0] up_q, up_d; // Clocks since reset release
  logic [31:0] idle_q, idle_d; // Still bus clock in a transfer
  logic scl_q, scl_d; // Last bus clock level
  // Uptime saturates so it never wraps
  always_comb begin
    up_d = (up_q[31:20] != 12'h000) ? up_q : up_q + 32'h0000_0001;
    idle_d = (!xfer_active || scl_in != scl_q) ? 32'h0000_0000 : idle_q + 32'h0000_0001;
    scl_d = scl_in;
  end
  // Registers only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      up_q <= 32'h0000_0000;
      idle_q <= 32'h0000_0000;
      scl_q <= 1'b1;
    end else begin
      up_q <= up_d;
      idle_q <= idle_d;
      scl_q <= scl_d;
    end
  end
  // ****************************************************************
  // Sequencer timing
  // ****************************************************************
  AST_PWRUP_QUIET: assert property (@(posedge clk_sys) disable iff (!nrst)
    up_q + 1 < PWRUP_CYC |-> !adc_en) else $error("early conversion");
  AST_PWRUP_START: assert property (@(posedge clk_sys) disable iff (!nrst)
    (up_q == PWRUP_CYC + 4) && !pd_strap |-> adc_en) else $error("no first conversion");
  AST_STRAP_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
    pd_strap && (up_q < PWRUP_CYC + 100) |-> !adc_en) else $error("strap ignored");
  AST_ACTIVE_MIN: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(adc_en) |-> adc_en [*8]) else $error("active period too short");
  // ****************************************************************
  // Register port and data line
  // ****************************************************************
  AST_ONE_OUTSTANDING: assert property (@(posedge bus_clk) disable iff (!nrst)
    req_valid && req_ready |=> !req_ready) else $error("second request taken");
  AST_ANSWER_BOUND: assert property (@(posedge bus_clk) disable iff (!nrst)
    req_valid && req_ready |-> ##[3:14] rsp_valid) else $error("answer missing");
  AST_RSP_PULSE: assert property (@(posedge bus_clk) disable iff (!nrst)
    rsp_valid |=> !rsp_valid) else $error("answer too long");
  AST_RDATA_STABLE: assert property (@(posedge bus_clk) disable iff (!nrst)
    !rsp_valid |-> $stable(rsp_rdata)) else $error("read data changed alone");
  AST_IDLE_RELEASE: assert property (@(posedge bus_clk) disable iff (!nrst)
    !sda_pull [*2] |-> sda_oe_n) else $error("data line driven unasked");
  AST_TMO_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
    sda_pull && idle_q > 12 && idle_q + 4 < TMO_CYC |-> !sda_oe_n) else $error("early release");
  AST_TMO_RELEASE: assert property (@(posedge clk_sys) disable iff (!nrst)
    idle_q > TMO_CYC + 12 |-> sda_oe_n && !sda_out) else $error("stuck bus not released");
endmodule // seq_monitor

bind temp_conversion_sequencer seq_monitor #(.PWRUP_CYC(PWRUP_CYC), .CYCLE_PERIOD_SELECT_CYC(CYCLE_PERIOD_SELECT_CYC),
  .MS_CYC(MS_CYC), .TMO_CYC(TMO_CYC)) seq_monitor_i (.clk_sys(clk_sys), .nrst(nrst),
  .bus_clk(bus_clk), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
  .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
  .xfer_active(xfer_active), .sda_pull(sda_pull), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .pd_strap(pd_strap), .adc_data(adc_data), .adc_en(adc_en));

// file: seq_host.sv
/*
  Stand-in protocol engine: register requests and bus pin levels.
  Assumes one request outstanding.
*/
`timescale 1ns/1ps
module seq_host (
  input wire logic bus_clk, // Link clock
  output logic req_valid, // Request offered
  input wire logic req_ready, // Request can be taken
  output logic req_write, // Write flag
  output logic [1:0] req_addr, // Register pointer
  output logic [15:0] req_wdata, // Write data
  input wire logic rsp_valid, // Answer pulse
  output logic xfer_active, // Transfer open
  output logic sda_pull, // Pull data line low
  output logic scl_in // Bus clock pin level
);
  int tmo = 0; // Waits that ran out
  // Idle, bus clock high as pulled up
  initial begin
    {req_valid, req_write, req_addr, req_wdata} = '0;
    {xfer_active, sda_pull, scl_in} = 3'b001;
  end
  // One request, held until taken
  task automatic access(input logic wr, input logic [1:0] a, input logic [15:0] d);
    int n = 0;
    @(negedge bus_clk);
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, wr, a, d};
    do @(posedge bus_clk) n++; while (req_ready !== 1'b1 && n < 40);
    if (n >= 40) tmo++;
    @(negedge bus_clk);
    // Released fields flip so stale values show
    {req_valid, req_write, req_addr, req_wdata} = {1'b0, ~wr, ~a, ~d};
    n = 0;
    do @(posedge bus_clk) n++; while (rsp_valid !== 1'b1 && n < 40);
    if (n >= 40) tmo++;
  endtask
  // Transfer and pin levels
  task automatic pins(input logic x, input logic p, input logic s);
    @(negedge bus_clk);
    {xfer_active, sda_pull, scl_in} = {x, p, s};
  endtask
endmodule // seq_host

// file: testbench.sv
/*
  Self-checking bench of the conversion sequencer.
  Assumes the monitor binds itself; counts are shortened.
*/
`timescale 1ns/1ps
`include "temp_seq_defs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %0t: got %0h, expected %0h", $time, got, exp); end end
module testbench;
  localparam int unsigned PWR = 20; // Shortened power-up
  localparam int unsigned CNV = 10; // Shortened conversion
  localparam int unsigned MSC = 4; // Clocks per millisecond
  localparam int unsigned TMO = 50; // Shortened bus timeout
  localparam int NS[4] = '{1, 8, 32, 64}; // Samples per code
  localparam int PMS[4] = '{16, 125, 250, 500}; // ms per period code
  logic clk_sys, nrst, bus_clk, pd_strap, adc_en, xfer_active, sda_pull, scl_in;
  logic req_valid, req_ready, req_write, rsp_valid, sda_out, sda_oe_n;
  logic [1:0] req_addr;
  logic [15:0] req_wdata, rsp_rdata, adc_data, v, r;
  logic [16:0] notes[$]; // Compare flag, expected word
  logic [16:0] note; // Note being retired
  int mismatches, total_checks, hi, lo, k;
  temp_conversion_sequencer #(.PWRUP_CYC(PWR), .CYCLE_PERIOD_SELECT_CYC(CNV), .MS_CYC(MSC), .TMO_CYC(TMO))
    temp_conversion_sequencer_i (.clk_sys(clk_sys), .nrst(nrst), .bus_clk(bus_clk),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .xfer_active(xfer_active), .sda_pull(sda_pull),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pd_strap(pd_strap),
    .adc_data(adc_data), .adc_en(adc_en));
  seq_host seq_host_i (.bus_clk(bus_clk), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .xfer_active(xfer_active), .sda_pull(sda_pull), .scl_in(scl_in));
  // ****************************************************************
  // Clocks, offset so edges never meet
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    bus_clk = 1'b0;
    #1.3;
    forever #3 bus_clk = ~bus_clk;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Access; v is write data or expected read
  task automatic acc(input logic wr, input logic [1:0] a, input logic [15:0] v);
    notes.push_back({~wr, wr ? 16'h0000 : v});
    seq_host_i.access(wr, a, v);
    if (seq_host_i.tmo != 0) begin
      mismatches++;
      test_done();
    end
  endtask
  // Clocks adc_en stays at lvl; a hang ends the run
  task automatic span(input logic lvl, output int n);
    n = 0;
    while (adc_en === lvl && n < 40000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 40000) begin
      mismatches++;
      test_done();
    end
  endtask
  // Clocks with adc_en high among the next n
  task automatic quiet(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk_sys);
      c += (adc_en === 1'b1);
    end
  endtask
  // ****************************************************************
  // Each answer retires the oldest note
  // ****************************************************************
  always @(posedge bus_clk) begin
    if (nrst === 1'b1 && rsp_valid === 1'b1) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("Error %0t: answer without request", $time);
      end else begin
        note = notes.pop_front();
        if (note[16]) `CHK(rsp_rdata, note[15:0])
      end
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    mismatches = 0;
    total_checks = 0;
    k = $urandom(32'h0000_fe36);
    v = 16'($urandom);
    {nrst, pd_strap, adc_data} = {1'b0, 1'b0, v};
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    // Power-up: writes dropped, reset values read
    acc(1'b1, `A_HI, 16'h1234);
    acc(1'b0, `A_HI, `RST_HI);
    acc(1'b0, `A_CFG, 16'h0220);
    acc(1'b0, `A_TEMP, 16'h8000);
    acc(1'b0, `A_LO, `RST_LO);
    $display("test power-up done");
    // Default cycle, fresh flag, limits, read-only result
    span(1'b1, hi);
    acc(1'b0, `A_CFG, 16'h2220);
    acc(1'b0, `A_TEMP, v);
    acc(1'b0, `A_CFG, 16'h0220);
    r = 16'($urandom);
    acc(1'b1, `A_HI, r);
    acc(1'b0, `A_HI, r);
    acc(1'b1, `A_LO, ~r);
    acc(1'b0, `A_LO, ~r);
    acc(1'b1, `A_TEMP, ~v);
    acc(1'b0, `A_TEMP, v);
    span(1'b0, lo);
    span(1'b1, hi);
    span(1'b0, lo);
    `CHK(hi, 8 * CNV)
    `CHK(hi + lo, 1000 * MSC)
    $display("test default cycle done");
    // All sample counts, four periods, selector 10 runs free
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, `A_CFG, 16'((i == 2 ? 2 : 0) << 10 | i << 7 | i << 5));
      span(1'b1, lo);
      span(1'b0, lo);
      span(1'b1, hi);
      span(1'b0, lo);
      `CHK(hi, NS[i] * CNV)
      `CHK(hi + lo, PMS[i] * MSC)
    end
    $display("test cycle codes done");
    // Power-down in mid-conversion stops at once
    acc(1'b1, `A_CFG, 16'h0600);
    repeat (4) @(negedge clk_sys);
    quiet(800, k);
    `CHK(k, 0)
    acc(1'b0, `A_TEMP, v);
    acc(1'b0, `A_CFG, 16'h0600);
    $display("test power-down done");
    // One-shot, eight samples
    r = 16'($urandom);
    @(negedge clk_sys);
    adc_data = r;
    fork
      acc(1'b1, `A_CFG, 16'h0e20);
      begin
        span(1'b0, lo);
        span(1'b1, hi);
      end
    join
    `CHK(hi, 8 * CNV)
    quiet(600, k);
    `CHK(k, 0)
    acc(1'b0, `A_CFG, 16'h2620);
    acc(1'b0, `A_TEMP, r);
    $display("test one-shot done");
    // Stuck bus clock releases the data line
    seq_host_i.pins(1'b1, 1'b1, 1'b1);
    repeat (30) @(negedge clk_sys);
    `CHK(sda_oe_n, 1'b0)
    repeat (TMO + 10) @(negedge clk_sys);
    `CHK(sda_oe_n, 1'b1)
    seq_host_i.pins(1'b1, 1'b1, 1'b0);
    repeat (20) @(negedge clk_sys);
    `CHK(sda_oe_n, 1'b0)
    `CHK(sda_out, 1'b0)
    seq_host_i.pins(1'b0, 1'b0, 1'b1);
    $display("test bus timeout done");
    // Second reset, start in power-down
    @(negedge clk_sys);
    {nrst, pd_strap} = 2'b01;
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    quiet(PWR + 200, k);
    `CHK(k, 0)
    acc(1'b0, `A_TEMP, 16'h8000);
    $display("test strap start done");
    test_done();
  end
endmodule // testbench
